/* File: src/nvc_defs.svh */
`ifndef NVC_DEFS_SVH
`define NVC_DEFS_SVH

// ==========================================
// Bus and counter widths
`define NVC_ADDR_W 15
`define NVC_MODE_ADDR_W 14
`define NVC_DATA_W 8
`define NVC_CNT_W 20

// ==========================================
// Clock and device timing
`define NVC_CLK_MHZ 50
`define NVC_STORE_MS 10
`define NVC_RECALL_US 20
`define NVC_PWRUP_US 550
`define NVC_STORE_CYC (`NVC_STORE_MS * 1000 * `NVC_CLK_MHZ)
`define NVC_RECALL_CYC (`NVC_RECALL_US * `NVC_CLK_MHZ)
`define NVC_PWRUP_CYC (`NVC_PWRUP_US * `NVC_CLK_MHZ)
// Three 20 ns cycles of select low covers every speed grade's pulse width
`define NVC_ACC_CYC 3

// ==========================================
// Software mode address sequence, lower 14 bits
`define NVC_SEQ_0 14'h0E38
`define NVC_SEQ_1 14'h31C7
`define NVC_SEQ_2 14'h03E0
`define NVC_SEQ_3 14'h3C1F
`define NVC_SEQ_4 14'h303F
`define NVC_SEQ_STORE 14'h0FC0
`define NVC_SEQ_RECALL 14'h0C63
`define NVC_SEQ_LAST 3'h5

`endif

/* File: src/nvc_pkg.sv */
`include "nvc_defs.svh"

package nvc_pkg;

    typedef enum logic [1:0] {
        NVC_OP_READ = 2'b00,
        NVC_OP_WRITE = 2'b01,
        NVC_OP_STORE = 2'b10,
        NVC_OP_RECALL = 2'b11
    } nvc_op_type;

    typedef enum logic [2:0] {
        NVC_ST_INIT = 3'b000,
        NVC_ST_PWRUP = 3'b001,
        NVC_ST_IDLE = 3'b010,
        NVC_ST_SETUP = 3'b011,
        NVC_ST_ACTIVE = 3'b100,
        NVC_ST_RELEASE = 3'b101,
        NVC_ST_NVWAIT = 3'b110
    } nvc_state_type;

    typedef struct packed {
        nvc_op_type op;
        logic [`NVC_ADDR_W-1:0] addr;
        logic [`NVC_DATA_W-1:0] wdata;
    } nvc_cmd_type;

    typedef struct packed {
        logic [`NVC_ADDR_W-1:0] address_lines;
        logic sel_n;
        logic wr_n;
        logic oe_n;
        logic [`NVC_DATA_W-1:0] data_lines;
        logic data_oe_n;
    } nvc_pins_type;

endpackage

/* File: src/nvc_timer.sv */
`timescale 1ns/1ps
`include "nvc_defs.svh"

module nvc_timer #(
    parameter int CNT_W = `NVC_CNT_W
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [CNT_W-1:0] load_val_i,
    output logic done_o
);

    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;

    generate
        if (CNT_W < 2) begin : g_bad_width
            $error("nvc_timer: CNT_W must be at least 2");
        end
    endgenerate

    always_comb begin
        count_next = count_reg;
        if (load_i) begin
            count_next = load_val_i;
        end else if (count_reg != '0) begin
            count_next = count_reg - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign done_o = (count_reg == '0);

endmodule

/* File: src/nvc_host.sv */
// Contract
// R1 - Read: select and gate low, strobe high
// R2 - Fifteen address bits pick one byte
// R3 - Enabled read follows address changes
// R4 - Write: select and strobe both low
// R5 - Byte captured when strobe or select rises
// R6 - Device drops drivers when strobe falls
// R7 - Store after six reads in fixed order
// R8 - Recall: same five, sixth is 0C63
// R9 - Detector ignores the top address bit
// R10 - Strobe stays high through the sequence
// R11 - No other access inside the sequence
// R12 - Toggle select once per sequence address
// R13 - Sequence valid with gate high or low
// R14 - Store erases then programs from SRAM
// R15 - Store floats pins up to 10 ms
// R16 - Recall clears SRAM then loads shadow
// R17 - Software recall done within 20 us
// R18 - Power-up recall done within 550 us
// R19 - No store below the low trigger
// R20 - Strobe or select high during power-up recall
// R21 - Address stable across the whole write
// R22 - Gate held high for the write
// R23 - Mismatched step returns detector to idle
`timescale 1ns/1ps
`include "nvc_defs.svh"

module nvc_host #(
    parameter int ACC_CYC = `NVC_ACC_CYC,
    parameter int STORE_CYC = `NVC_STORE_CYC,
    parameter int RECALL_CYC = `NVC_RECALL_CYC,
    parameter int PWRUP_CYC = `NVC_PWRUP_CYC,
    parameter int CNT_W = `NVC_CNT_W
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic cmd_valid_i,
    input nvc_pkg::nvc_cmd_type cmd_i,
    output logic cmd_ready_o,
    output logic rsp_valid_o,
    output logic [`NVC_DATA_W-1:0] rsp_data_o,
    output nvc_pkg::nvc_pins_type pins_o,
    input wire logic [`NVC_DATA_W-1:0] data_lines_i
);

    // ==========================================
    // Parameter checks
    generate
        if (ACC_CYC < 1 || ACC_CYC > 64) begin : g_bad_acc
            $error("nvc_host: ACC_CYC out of range");
        end
        if (STORE_CYC < 1 || RECALL_CYC < 1 || PWRUP_CYC < 1) begin : g_bad_wait
            $error("nvc_host: wait counts must be positive");
        end
        if (STORE_CYC >= 2**CNT_W || RECALL_CYC >= 2**CNT_W || PWRUP_CYC >= 2**CNT_W) begin : g_bad_cnt
            $error("nvc_host: CNT_W too narrow for wait counts");
        end
    endgenerate

    // ==========================================
    // State
    nvc_pkg::nvc_state_type state_reg, state_next;
    nvc_pkg::nvc_cmd_type cmd_reg, cmd_next;
    nvc_pkg::nvc_pins_type pins_reg, pins_next;
    logic [2:0] idx_reg, idx_next;
    logic [`NVC_DATA_W-1:0] rdata_reg, rdata_next;
    logic rsp_reg, rsp_next;
    logic ready_reg, ready_next;
    logic tload;
    logic [CNT_W-1:0] tval;
    logic tdone;
    logic seq_op;
    logic seq_op_next;
    logic is_write_next;

    // Sequence step address; top bit is driven low since the device ignores it
    function automatic logic [`NVC_MODE_ADDR_W-1:0] seq_addr(input nvc_pkg::nvc_op_type op,
                                                             input logic [2:0] idx);
        logic [`NVC_MODE_ADDR_W-1:0] a;
        a = `NVC_SEQ_0;
        case (idx)
            3'h0: a = `NVC_SEQ_0;
            3'h1: a = `NVC_SEQ_1;
            3'h2: a = `NVC_SEQ_2;
            3'h3: a = `NVC_SEQ_3;
            3'h4: a = `NVC_SEQ_4;
            3'h5: a = (op == nvc_pkg::NVC_OP_STORE) ? `NVC_SEQ_STORE : `NVC_SEQ_RECALL; // [R7] [R8]
            default: a = `NVC_SEQ_0;
        endcase
        return a;
    endfunction

    assign seq_op = cmd_reg.op[1];
    assign seq_op_next = cmd_next.op[1];
    assign is_write_next = (cmd_next.op == nvc_pkg::NVC_OP_WRITE);

    nvc_timer #(
        .CNT_W(CNT_W)
    ) u_timer (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .load_i(tload),
        .load_val_i(tval),
        .done_o(tdone)
    );

    // ==========================================
    // Sequencer
    always_comb begin
        state_next = state_reg;
        cmd_next = cmd_reg;
        idx_next = idx_reg;
        rdata_next = rdata_reg;
        rsp_next = 1'b0;
        tload = 1'b0;
        tval = '0;
        case (state_reg)
            nvc_pkg::NVC_ST_INIT: begin
                tload = 1'b1;
                tval = CNT_W'(PWRUP_CYC);
                state_next = nvc_pkg::NVC_ST_PWRUP;
            end
            nvc_pkg::NVC_ST_PWRUP: begin
                if (tdone) begin
                    state_next = nvc_pkg::NVC_ST_IDLE;
                end
            end
            nvc_pkg::NVC_ST_IDLE: begin
                if (cmd_valid_i) begin
                    cmd_next = cmd_i;
                    idx_next = 3'h0;
                    state_next = nvc_pkg::NVC_ST_SETUP;
                end
            end
            nvc_pkg::NVC_ST_SETUP: begin
                tload = 1'b1;
                tval = CNT_W'(ACC_CYC - 1);
                state_next = nvc_pkg::NVC_ST_ACTIVE;
            end
            nvc_pkg::NVC_ST_ACTIVE: begin
                if (tdone) begin
                    if (cmd_reg.op == nvc_pkg::NVC_OP_READ) begin
                        rdata_next = data_lines_i;
                    end
                    state_next = nvc_pkg::NVC_ST_RELEASE;
                end
            end
            nvc_pkg::NVC_ST_RELEASE: begin
                if (seq_op) begin
                    // Steps run back to back so nothing else can slip in
                    if (idx_reg != `NVC_SEQ_LAST) begin
                        idx_next = idx_reg + 3'h1; // [R11]
                        state_next = nvc_pkg::NVC_ST_SETUP;
                    end else begin
                        tload = 1'b1;
                        tval = (cmd_reg.op == nvc_pkg::NVC_OP_STORE) ? CNT_W'(STORE_CYC) : CNT_W'(RECALL_CYC); // [R15] [R17]
                        state_next = nvc_pkg::NVC_ST_NVWAIT;
                    end
                end else begin
                    rsp_next = 1'b1;
                    state_next = nvc_pkg::NVC_ST_IDLE;
                end
            end
            nvc_pkg::NVC_ST_NVWAIT: begin
                if (tdone) begin
                    rsp_next = 1'b1;
                    state_next = nvc_pkg::NVC_ST_IDLE;
                end
            end
            default: begin
                state_next = nvc_pkg::NVC_ST_INIT;
            end
        endcase
    end

    // ==========================================
    // Pin drive, decoded from the next state so every pin leaves a flip-flop
    always_comb begin
        pins_next = pins_reg;
        pins_next.sel_n = 1'b1; // [R20]
        pins_next.wr_n = 1'b1;
        pins_next.oe_n = 1'b1;
        pins_next.data_oe_n = 1'b1;
        ready_next = (state_next == nvc_pkg::NVC_ST_IDLE);
        case (state_next)
            nvc_pkg::NVC_ST_SETUP: begin
                // Address settles one cycle before any strobe falls
                if (seq_op_next) begin
                    pins_next.address_lines = {1'b0, seq_addr(cmd_next.op, idx_next)}; // [R7] [R8]
                end else begin
                    pins_next.address_lines = cmd_next.addr; // [R21]
                end
                pins_next.data_lines = cmd_next.wdata;
                pins_next.data_oe_n = !is_write_next;
            end
            nvc_pkg::NVC_ST_ACTIVE: begin
                pins_next.sel_n = 1'b0; // [R12]
                pins_next.wr_n = !is_write_next; // [R4] [R10]
                // Gate only on plain reads: stays high for writes and sequence steps
                pins_next.oe_n = !(cmd_next.op == nvc_pkg::NVC_OP_READ); // [R1] [R22] [R13]
                pins_next.data_oe_n = !is_write_next;
            end
            nvc_pkg::NVC_ST_RELEASE: begin
                // Data held one cycle past the rising strobe
                pins_next.data_oe_n = !is_write_next; // [R5]
            end
            default: begin
                pins_next.data_oe_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= nvc_pkg::NVC_ST_INIT;
            cmd_reg <= '0;
            idx_reg <= 3'h0;
            rdata_reg <= '0;
            rsp_reg <= 1'b0;
            ready_reg <= 1'b0;
            pins_reg <= '{address_lines: '0, sel_n: 1'b1, wr_n: 1'b1, oe_n: 1'b1,
                          data_lines: '0, data_oe_n: 1'b1};
        end else begin
            state_reg <= state_next;
            cmd_reg <= cmd_next;
            idx_reg <= idx_next;
            rdata_reg <= rdata_next;
            rsp_reg <= rsp_next;
            ready_reg <= ready_next;
            pins_reg <= pins_next;
        end
    end

    assign cmd_ready_o = ready_reg;
    assign rsp_valid_o = rsp_reg;
    assign rsp_data_o = rdata_reg;
    assign pins_o = pins_reg;

    // ==========================================
    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence seq_nv_start;
        $rose(state_reg == nvc_pkg::NVC_ST_NVWAIT);
    endsequence

    sequence seq_step_fall;
        $fell(pins_reg.sel_n) && seq_op;
    endsequence

    seq_write_high_a: // [R10]
    assert property (seq_op && state_reg != nvc_pkg::NVC_ST_IDLE |-> pins_reg.wr_n)
        else $error("write strobe low during software sequence");

    write_gate_high_a: // [R22]
    assert property (!pins_reg.wr_n |-> pins_reg.oe_n && !pins_reg.data_oe_n)
        else $error("gate low or data undriven during write");

    write_addr_stable_a: // [R21]
    assert property ((!pins_reg.wr_n || $rose(pins_reg.wr_n)) |-> $stable(pins_reg.address_lines))
        else $error("address moved during write");

    pwrup_quiet_a: // [R20]
    assert property (state_reg == nvc_pkg::NVC_ST_PWRUP |-> pins_reg.sel_n && pins_reg.wr_n)
        else $error("select or strobe low during power-up recall wait");

    step_first_addr_a: // [R7]
    assert property (seq_step_fall and (idx_reg == 3'h0) |-> pins_reg.address_lines == {1'b0, `NVC_SEQ_0})
        else $error("first sequence address wrong");

    step_last_addr_a: // [R8]
    assert property (seq_step_fall and (idx_reg == `NVC_SEQ_LAST) |->
                     pins_reg.address_lines[`NVC_MODE_ADDR_W-1:0] ==
                     ((cmd_reg.op == nvc_pkg::NVC_OP_STORE) ? `NVC_SEQ_STORE : `NVC_SEQ_RECALL))
        else $error("sixth sequence address wrong");

    step_no_gap_a: // [R11]
    assert property (seq_op && state_reg == nvc_pkg::NVC_ST_RELEASE && idx_reg != `NVC_SEQ_LAST |=>
                     state_reg == nvc_pkg::NVC_ST_SETUP ##1 $fell(pins_reg.sel_n))
        else $error("other access between sequence steps");

    step_sel_pulse_a: // [R12]
    assert property (seq_step_fall |-> (!pins_reg.sel_n && $stable(pins_reg.address_lines)) [*3]
                     ##1 pins_reg.sel_n)
        else $error("sequence step not a select pulse");

    nv_wait_quiet_a: // [R15]
    assert property (seq_nv_start |-> (pins_reg.sel_n && pins_reg.data_oe_n) [*8])
        else $error("pins active during nonvolatile wait");

    read_answer_a: // [R1]
    assert property (state_reg == nvc_pkg::NVC_ST_IDLE && cmd_valid_i && cmd_i.op == nvc_pkg::NVC_OP_READ |->
                     ##[3:70] rsp_valid_o)
        else $error("read answer late");

endmodule

/* File: bench/nvc_dev_model.sv */
`timescale 1ns/1ps
`include "nvc_defs.svh"

module nvc_dev_model #(
    parameter int STORE_DUR = 40,
    parameter int RECALL_DUR = 8,
    parameter int PWRUP_DUR = 15
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic supply_low_i,
    input nvc_pkg::nvc_pins_type pins_i,
    output logic [`NVC_DATA_W-1:0] data_o,
    output int err_o
);
    // ==========================================
    // Arrays and read path
    logic [7:0] sram [0:32767];
    logic [7:0] shadow [0:32767];
    nvc_pkg::nvc_pins_type prev;
    int busy_cnt;
    logic [1:0] op;
    logic [2:0] step;
    logic [13:0] a14;
    logic [7:0] last_q;
    logic rd;

    initial begin
        for (int i = 0; i < 32768; i++) begin
            shadow[i] = i[7:0] ^ 8'hA5;
        end
    end

    // Gate, select, strobe and the busy count decide; a low strobe turns drivers off at once
    assign rd = !pins_i.sel_n && !pins_i.oe_n && pins_i.wr_n && busy_cnt == 0;
    // Released lines show the inverse of the last byte so a stale sample cannot pass
    assign data_o = rd ? sram[pins_i.address_lines] : ~last_q;

    function automatic logic [13:0] seq_addr(input logic [2:0] s);
        case (s)
            3'h0: return `NVC_SEQ_0;
            3'h1: return `NVC_SEQ_1;
            3'h2: return `NVC_SEQ_2;
            3'h3: return `NVC_SEQ_3;
            default: return `NVC_SEQ_4;
        endcase
    endfunction

    task automatic finish_op();
        if (op == 2'h1) begin
            for (int i = 0; i < 32768; i++) shadow[i] = 8'hFF;
            for (int i = 0; i < 32768; i++) shadow[i] = sram[i];
        end else if (op == 2'h2) begin
            for (int i = 0; i < 32768; i++) sram[i] = 8'h00;
            for (int i = 0; i < 32768; i++) sram[i] = shadow[i];
        end
    endtask

    // ==========================================
    // Access, sequence detector and nonvolatile timing
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            busy_cnt <= PWRUP_DUR;
            op <= 2'h2;
            step <= 3'h0;
            prev <= '1;
            last_q <= 8'h00;
            err_o <= 0;
        end else begin
            prev <= pins_i;
            if (rd) last_q <= data_o;
            if (busy_cnt != 0) begin
                // Pins are dead while busy; any select counts as a host fault
                if (!pins_i.sel_n) err_o <= err_o + 1;
                if (busy_cnt == 1 && op == 2'h2 && !pins_i.sel_n && !pins_i.wr_n) err_o <= err_o + 1;
                if (busy_cnt == 1) finish_op();
                busy_cnt <= busy_cnt - 1;
            end else begin
                if (!prev.sel_n && !prev.wr_n && (pins_i.sel_n || pins_i.wr_n)) begin
                    sram[prev.address_lines] <= prev.data_lines;
                    if (prev.data_oe_n) err_o <= err_o + 1;
                end
                if (!pins_i.sel_n && !pins_i.wr_n) begin
                    step <= 3'h0;
                    if (!pins_i.oe_n) err_o <= err_o + 1;
                    if (!prev.sel_n && !prev.wr_n && pins_i.address_lines != prev.address_lines) err_o <= err_o + 1;
                end
                if (!prev.sel_n && pins_i.sel_n && prev.wr_n) begin
                    a14 = prev.address_lines[13:0];
                    if (step == `NVC_SEQ_LAST && a14 == `NVC_SEQ_STORE) begin
                        step <= 3'h0;
                        if (!supply_low_i) begin
                            op <= 2'h1;
                            busy_cnt <= STORE_DUR;
                        end
                    end else if (step == `NVC_SEQ_LAST && a14 == `NVC_SEQ_RECALL) begin
                        step <= 3'h0;
                        op <= 2'h2;
                        busy_cnt <= RECALL_DUR;
                    end else if (step < `NVC_SEQ_LAST && a14 == seq_addr(step)) begin
                        step <= step + 3'h1;
                    end else begin
                        step <= (a14 == `NVC_SEQ_0) ? 3'h1 : 3'h0;
                    end
                end
            end
        end
    end
endmodule

/* File: bench/nvc_host_test.sv */
`timescale 1ns/1ps
`include "nvc_defs.svh"

module nvc_host_test;
    logic clock_i;
    logic rst_i;
    logic cmd_valid;
    logic supply_low;
    nvc_pkg::nvc_cmd_type cmd;
    logic cmd_ready_o;
    logic rsp_valid_o;
    logic [7:0] rsp_data_o;
    nvc_pkg::nvc_pins_type pins;
    logic [7:0] dev_data;
    int dev_err;
    int n_mismatch;
    int num_checks;
    int lat;
    logic [7:0] rdata;

    nvc_host #(.PWRUP_CYC(20), .STORE_CYC(50), .RECALL_CYC(10)) i_dut (
        .clock_i(clock_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
        .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
        .pins_o(pins), .data_lines_i(dev_data));

    // Model defaults stay below the host's shortened waits, so the host never hits a busy device
    nvc_dev_model i_dev (
        .clock_i(clock_i), .rst_i(rst_i), .supply_low_i(supply_low), .pins_i(pins),
        .data_o(dev_data), .err_o(dev_err));

    // ==========================================
    // Shared tasks
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
            n_mismatch++;
        end
    endtask

    task automatic do_cmd(input nvc_pkg::nvc_op_type op, input logic [14:0] a, input logic [7:0] d);
        int n;
        @(posedge clock_i);
        cmd_valid <= 1'b1;
        cmd <= '{op: op, addr: a, wdata: d};
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (cmd_ready_o !== 1'b1 && n < 2000);
        cmd_valid <= 1'b0;
        lat = 0;
        do begin
            @(posedge clock_i);
            #1;
            lat++;
        end while (rsp_valid_o !== 1'b1 && lat < 2000);
        if (n >= 2000 || lat >= 2000) begin
            $display("wrong value handshake expected done seen timeout");
            n_mismatch++;
            end_sim();
        end
        rdata = rsp_data_o;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_powerup();
        do_cmd(nvc_pkg::NVC_OP_READ, 15'h0005, 8'h00);
        check("powerup byte", rdata, 8'h05 ^ 8'hA5);
        $display("test powerup done");
    endtask

    task automatic t_rw();
        do_cmd(nvc_pkg::NVC_OP_WRITE, 15'h0123, 8'h3C);
        check("write latency", lat, `NVC_ACC_CYC + 2);
        do_cmd(nvc_pkg::NVC_OP_WRITE, 15'h4123, 8'hC3);
        do_cmd(nvc_pkg::NVC_OP_READ, 15'h0123, 8'h00);
        check("read latency", lat, `NVC_ACC_CYC + 2);
        check("low half byte", rdata, 8'h3C);
        do_cmd(nvc_pkg::NVC_OP_READ, 15'h4123, 8'h00);
        check("high half byte", rdata, 8'hC3);
        do_cmd(nvc_pkg::NVC_OP_READ, 15'h0124, 8'h00);
        check("neighbour byte", rdata, 8'h24 ^ 8'hA5);
        $display("test read write done");
    endtask

    task automatic t_store_recall();
        do_cmd(nvc_pkg::NVC_OP_WRITE, 15'h0010, 8'h5A);
        do_cmd(nvc_pkg::NVC_OP_STORE, 15'h0000, 8'h00);
        do_cmd(nvc_pkg::NVC_OP_WRITE, 15'h0010, 8'h00);
        do_cmd(nvc_pkg::NVC_OP_RECALL, 15'h0000, 8'h00);
        do_cmd(nvc_pkg::NVC_OP_READ, 15'h0010, 8'h00);
        check("recalled byte", rdata, 8'h5A);
        do_cmd(nvc_pkg::NVC_OP_READ, 15'h4010, 8'h00);
        check("stored copy", rdata, 8'h10 ^ 8'hA5);
        check("device faults", dev_err, 0);
        $display("test store recall done");
    endtask

    task automatic t_inhibit();
        @(posedge clock_i);
        supply_low <= 1'b1;
        do_cmd(nvc_pkg::NVC_OP_WRITE, 15'h0010, 8'h77);
        do_cmd(nvc_pkg::NVC_OP_STORE, 15'h0000, 8'h00);
        @(posedge clock_i);
        supply_low <= 1'b0;
        do_cmd(nvc_pkg::NVC_OP_RECALL, 15'h0000, 8'h00);
        do_cmd(nvc_pkg::NVC_OP_READ, 15'h0010, 8'h00);
        check("inhibited store", rdata, 8'h5A);
        check("device faults", dev_err, 0);
        $display("test store inhibit done");
    endtask

    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    initial begin
        rst_i = 1'b1;
        cmd_valid = 1'b0;
        cmd = '0;
        supply_low = 1'b0;
        n_mismatch = 0;
        num_checks = 0;
        repeat (6) @(posedge clock_i);
        rst_i <= 1'b0;
        t_powerup();
        t_rw();
        t_store_recall();
        t_inhibit();
        end_sim();
    end
endmodule
